// file: pkg/gpio_io_logic_cell_consts.vh
// Constants for the general-purpose I/O logic cell.
// Assumes a single system clock samples every core clock and the pad.
//
// Function
// - Input mode enables receive path only, direct or registered.
// - Registered receive captures on the configured input-clock edge.
// - Alternate receive path drives the alternate function, never registered.
// - Alternate input feeds another interface block directly, bypassing core.
// - Double-rate receive samples pad on both input-clock edges, two streams.
// - Output mode enables transmit path only, registered or unregistered.
// - Registered transmit updates on the configured output-clock edge.
// - Output register value may be inverted in output and bidir modes.
// - Double-rate transmit captures both edges, multiplexed onto one pad.
// - Bidirectional mode enables receive, transmit and output-enable paths.
// - Bidir: input clock for receive, output clock for transmit and enable.
// - Each register picks its edge; receive and transmit register independently.
// - Output-enable register switches the pad driver in bidir mode; output mode always drives.
// - Clock-output mode drives the core clock-tree signal onto the pad.
// - During configuration ordinary pins sit in weak pull-up.
// - During configuration differential-capable pins float, no pull resistors.
// - Unused pins in user mode float with weak pull-up by default.
// - An option swaps the default pull-up on unused pins for pull-down; differential-capable pins then float.
// - Double-rate rise sample goes to first bit, fall sample second.
// - Resync passes both double-rate bits on the rising edge only.
// - Resync delivers the fall sample half a clock after its capture.

`ifndef GPIO_IO_LOGIC_CELL_CONSTS_VH
`define GPIO_IO_LOGIC_CELL_CONSTS_VH

// Pin modes
`define MODE_INPUT   2'h0
`define MODE_OUTPUT  2'h1
`define MODE_BIDIR   2'h2
`define MODE_CLKOUT  2'h3

// Reset values
`define RST_BIT      1'h0
`define RST_SYNC     3'h0

// Synchroniser stage positions
`define SYNC_MID     1
`define SYNC_LAST    2

`endif

// file: core/gpio_io_logic_cell.v
// General-purpose I/O logic cell between core fabric and one pad.
// Assumes core clocks and pad arrive unsynchronised; core data is on clk.
`timescale 1ns/1ns
`include "gpio_io_logic_cell_consts.vh"

module gpio_io_logic_cell
(
	// System
	input  wire       clk,
	input  wire       rst,
	// Configuration
	input  wire [1:0] mode,
	input  wire       cfg_active,
	input  wire       pin_used,
	input  wire       diff_capable,
	input  wire       pulldown_sel,
	input  wire       rx_reg_en,
	input  wire       rx_edge_fall,
	input  wire       rx_ddr,
	input  wire       rx_resync,
	input  wire       tx_reg_en,
	input  wire       tx_edge_fall,
	input  wire       tx_invert,
	input  wire       tx_ddr,
	input  wire       tx_resync,
	input  wire       oe_reg_en,
	input  wire       oe_edge_fall,
	// Core clocks
	input  wire       rx_capture_clock,
	input  wire       tx_launch_clock,
	input  wire       core_clock_tree,
	// Core data
	input  wire       tx_rise_bit,
	input  wire       tx_fall_bit,
	input  wire       oe_in,
	output reg        rx_rise_bit,
	output reg        rx_fall_bit,
	output reg        alternate_rx_path,
	// Pad
	input  wire       pad_i,
	output reg        pad_o,
	output reg        pad_oe,
	output reg        pad_pullup,
	output reg        pad_pulldown
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function edge_hit;
		input [2:0] s;
		input       fall;
		begin
			if (fall)
				edge_hit = s[`SYNC_LAST] & ~s[`SYNC_MID];
			else
				edge_hit = s[`SYNC_MID] & ~s[`SYNC_LAST];
		end
	endfunction

	// ------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------
	reg  [2:0] rxclk_s_q;
	reg  [2:0] txclk_s_q;
	reg  [2:0] tree_s_q;
	reg  [2:0] pad_s_q;
	reg        pad_v_q;
	reg        txclk_v_q;
	reg        tree_v_q;

	always @(posedge clk)
	begin
		if (rst)
		begin
			rxclk_s_q <= `RST_SYNC;
			txclk_s_q <= `RST_SYNC;
			tree_s_q  <= `RST_SYNC;
			pad_s_q   <= `RST_SYNC;
			pad_v_q   <= `RST_BIT;
			txclk_v_q <= `RST_BIT;
			tree_v_q  <= `RST_BIT;
		end
		else
		begin
			rxclk_s_q <= {rxclk_s_q[1:0], rx_capture_clock};
			txclk_s_q <= {txclk_s_q[1:0], tx_launch_clock};
			tree_s_q  <= {tree_s_q[1:0], core_clock_tree};
			pad_s_q   <= {pad_s_q[1:0], pad_i};
			if (pad_s_q[`SYNC_MID] == pad_s_q[`SYNC_LAST])
				pad_v_q <= pad_s_q[`SYNC_LAST];
			if (txclk_s_q[`SYNC_MID] == txclk_s_q[`SYNC_LAST])
				txclk_v_q <= txclk_s_q[`SYNC_LAST];
			if (tree_s_q[`SYNC_MID] == tree_s_q[`SYNC_LAST])
				tree_v_q <= tree_s_q[`SYNC_LAST];
		end
	end

	wire rx_rise = edge_hit(rxclk_s_q, 1'h0);
	wire rx_fall = edge_hit(rxclk_s_q, 1'h1);
	wire rx_sel  = edge_hit(rxclk_s_q, rx_edge_fall);
	wire tx_rise = edge_hit(txclk_s_q, 1'h0);
	wire tx_fall = edge_hit(txclk_s_q, 1'h1);
	wire tx_sel  = edge_hit(txclk_s_q, tx_edge_fall);
	wire oe_sel  = edge_hit(txclk_s_q, oe_edge_fall);

	wire rx_on = (mode == `MODE_INPUT) | (mode == `MODE_BIDIR);
	wire tx_on = (mode == `MODE_OUTPUT) | (mode == `MODE_BIDIR);

	// ------------------------------------------------------------
	// Receive registers
	// ------------------------------------------------------------
	reg rx_cap_q;
	reg rx_hi_q;
	reg rx_lo_q;
	reg rx_lo_rs_q;

	always @(posedge clk)
	begin
		if (rst)
		begin
			rx_cap_q   <= `RST_BIT;
			rx_hi_q    <= `RST_BIT;
			rx_lo_q    <= `RST_BIT;
			rx_lo_rs_q <= `RST_BIT;
		end
		else
		begin
			if (rx_sel)
				rx_cap_q <= pad_v_q;
			if (rx_rise)
				rx_hi_q <= pad_v_q;
			if (rx_fall)
				rx_lo_q <= pad_v_q;
			if (rx_rise)
				rx_lo_rs_q <= rx_lo_q;
		end
	end

	// ------------------------------------------------------------
	// Receive outputs
	// ------------------------------------------------------------
	reg rx_rise_d;
	reg rx_fall_d;

	always @*
	begin
		rx_rise_d = `RST_BIT;
		rx_fall_d = `RST_BIT;
		if (rx_on)
		begin
			if (rx_ddr)
			begin
				rx_rise_d = rx_hi_q;
				rx_fall_d = rx_resync ? rx_lo_rs_q : rx_lo_q;
			end
			else if (rx_reg_en)
				rx_rise_d = rx_cap_q;
			else
				rx_rise_d = pad_v_q;
		end
	end

	// ------------------------------------------------------------
	// Transmit and enable registers
	// ------------------------------------------------------------
	reg tx_reg_q;
	reg tx_hi_q;
	reg tx_lo_q;
	reg oe_reg_q;

	always @(posedge clk)
	begin
		if (rst)
		begin
			tx_reg_q <= `RST_BIT;
			tx_hi_q  <= `RST_BIT;
			tx_lo_q  <= `RST_BIT;
			oe_reg_q <= `RST_BIT;
		end
		else
		begin
			if (tx_sel)
				tx_reg_q <= tx_rise_bit;
			if (tx_rise)
				tx_hi_q <= tx_rise_bit;
			if (tx_resync ? tx_rise : tx_fall)
				tx_lo_q <= tx_fall_bit;
			if (oe_sel)
				oe_reg_q <= oe_in;
		end
	end

	// ------------------------------------------------------------
	// Pad drive
	// ------------------------------------------------------------
	reg tx_val;
	reg oe_val;
	reg pad_o_d;
	reg pad_oe_d;
	reg pad_pu_d;
	reg pad_pd_d;

	always @*
	begin
		if (tx_ddr)
			tx_val = txclk_v_q ? tx_hi_q : tx_lo_q;
		else if (tx_reg_en)
			tx_val = tx_reg_q;
		else
			tx_val = tx_rise_bit;
		if (tx_invert & (tx_ddr | tx_reg_en))
			tx_val = ~tx_val;
		oe_val = oe_reg_en ? oe_reg_q : oe_in;
		pad_o_d  = `RST_BIT;
		pad_oe_d = `RST_BIT;
		pad_pu_d = `RST_BIT;
		pad_pd_d = `RST_BIT;
		if (cfg_active)
		begin
			pad_pu_d = ~diff_capable;
		end
		else if (!pin_used)
		begin
			pad_pu_d = ~pulldown_sel;
			pad_pd_d = pulldown_sel & ~diff_capable;
		end
		else
		begin
			case (mode)
			`MODE_OUTPUT:
			begin
				pad_o_d  = tx_val;
				pad_oe_d = 1'h1;
			end
			`MODE_BIDIR:
			begin
				pad_o_d  = tx_val;
				pad_oe_d = oe_val;
			end
			`MODE_CLKOUT:
			begin
				pad_o_d  = tree_v_q;
				pad_oe_d = 1'h1;
			end
			default:
			begin
				pad_o_d  = `RST_BIT;
				pad_oe_d = `RST_BIT;
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Output flops
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		if (rst)
		begin
			rx_rise_bit       <= `RST_BIT;
			rx_fall_bit       <= `RST_BIT;
			alternate_rx_path <= `RST_BIT;
			pad_o             <= `RST_BIT;
			pad_oe            <= `RST_BIT;
			pad_pullup        <= `RST_BIT;
			pad_pulldown      <= `RST_BIT;
		end
		else
		begin
			rx_rise_bit <= rx_rise_d;
			rx_fall_bit <= rx_fall_d;
			alternate_rx_path <= pad_v_q;
			pad_o        <= pad_o_d;
			pad_oe       <= pad_oe_d;
			pad_pullup   <= pad_pu_d;
			pad_pulldown <= pad_pd_d;
		end
	end

endmodule

// file: testbench/gpio_io_logic_cell_checker.sv
// Assertion checker for the I/O logic cell, bound to its top ports.
// Assumes outputs follow the inputs one clk later, as registered.
`timescale 1ns/1ns
`include "gpio_io_logic_cell_consts.vh"
module gpio_io_logic_cell_checker
(
	// System
	input wire       clk, rst,
	// Configuration
	input wire [1:0] mode,
	input wire       cfg_active, pin_used, diff_capable, pulldown_sel,
	input wire       rx_reg_en, rx_ddr, tx_reg_en, tx_ddr,
	// Core and pad
	input wire       tx_rise_bit, pad_i, rx_rise_bit, rx_fall_bit,
	input wire       alternate_rx_path, pad_o, pad_oe,
	input wire       pad_pullup, pad_pulldown
);
	reg  run_q = 1'h0;
	wire user  = !cfg_active && pin_used;
	wire in_on = user && mode == `MODE_INPUT;
	wire tx_on = user && mode == `MODE_OUTPUT && !tx_reg_en && !tx_ddr;
	// ---------------------------------------------
	// Properties
	// ---------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	always @(posedge clk)
		run_q <= !rst;
	AST_CFG_UP: assert property (
		run_q && cfg_active && !diff_capable |=> pad_pullup
		&& !pad_pulldown && !pad_oe) else $error("no pull-up in config");
	AST_CFG_FLOAT: assert property (
		run_q && cfg_active && diff_capable |=> !pad_pullup
		&& !pad_pulldown && !pad_oe) else $error("pull on diff pin");
	AST_UNUSED: assert property (
		run_q && !cfg_active && !pin_used && !diff_capable |=> !pad_oe
		&& pad_pulldown == $past(pulldown_sel)
		&& pad_pullup == !$past(pulldown_sel)) else $error("unused pull");
	AST_IN_OFF: assert property (
		run_q && in_on |=> !pad_oe) else $error("driver on in input");
	AST_TX_DIRECT: assert property (
		run_q && tx_on |=> pad_oe && pad_o == $past(tx_rise_bit))
		else $error("direct transmit wrong");
	AST_ALT: assert property (
		(in_on && $stable(pad_i)) [*7] |=> alternate_rx_path == $past(pad_i))
		else $error("alternate path wrong");
	AST_RX_DIRECT: assert property (
		(in_on && !rx_reg_en && !rx_ddr && $stable(pad_i)) [*7]
		|=> rx_rise_bit == $past(pad_i)) else $error("direct rx wrong");
	AST_FALL_ZERO: assert property (
		(!rx_ddr) [*2] |=> !rx_fall_bit) else $error("fall bit set");
endmodule
bind gpio_io_logic_cell gpio_io_logic_cell_checker chk (.*);

// file: testbench/gpio_io_logic_cell_partner.sv
// Core fabric and pad model facing the I/O logic cell.
// Assumes the bench sets the far pad level and the core data bits.
`timescale 1ns/1ns
module gpio_io_logic_cell_partner
(
	// Clock
	input  wire clk,
	// Bench side
	input  wire ext_en, ext_val, hi, lo,
	// Cell pad side
	input  wire pad_o, pad_oe, pad_pullup, pad_pulldown,
	// Cell inputs
	output wire pad_i, rx_capture_clock, tx_launch_clock,
	output wire core_clock_tree, tx_rise_bit, tx_fall_bit
);
	reg [3:0] cnt_q  = 4'h0;
	reg       last_q = 1'h0;
	// Core clocks: 16 clk period, 8 high and 8 low
	always @(posedge clk)
		cnt_q <= cnt_q + 4'h1;
	assign rx_capture_clock = cnt_q[3];
	assign core_clock_tree  = cnt_q[3];
	assign tx_launch_clock  = cnt_q[3] ^ cnt_q[2];
	assign tx_rise_bit = hi;
	assign tx_fall_bit = lo;
	// driver wins, then far side, pull, else churn
	always @(posedge clk)
		last_q <= pad_i;
	assign pad_i = pad_oe ? pad_o : ext_en ? ext_val
		: pad_pullup ? 1'h1 : pad_pulldown ? 1'h0 : ~last_q;
endmodule

// file: testbench/gpio_io_logic_cell_tb.sv
// Testbench for the I/O logic cell with its core and pad model.
// Assumes free-running core clocks from the model, 16 clk period.
`timescale 1ns/1ns
`include "gpio_io_logic_cell_consts.vh"
module gpio_io_logic_cell_tb;
	reg clk = 0, rst = 1, cfg_active = 0, pin_used = 1;
	reg [1:0] mode = `MODE_INPUT;
	reg diff_capable = 0, pulldown_sel = 0, rx_reg_en = 0, rx_ddr = 0;
	reg rx_edge_fall = 0, rx_resync = 0, tx_reg_en = 0, tx_ddr = 0;
	reg tx_edge_fall = 0, tx_invert = 0, tx_resync = 0, oe_reg_en = 0;
	reg oe_edge_fall = 0, oe_in = 0, ext_en = 1, ext_val = 0;
	reg hi = 0, lo = 0;
	wire rx_capture_clock, tx_launch_clock, core_clock_tree, pad_i;
	wire tx_rise_bit, tx_fall_bit, rx_rise_bit, rx_fall_bit, pad_o;
	wire alternate_rx_path, pad_oe, pad_pullup, pad_pulldown;
	wire [1:0] cks = {tx_launch_clock, rx_capture_clock};
	integer error_cnt = 0, checks = 0, i;
	always #20 clk = ~clk;
	gpio_io_logic_cell uut (.*);
	gpio_io_logic_cell_partner core_pad (.*);
	// ---------------------------------------------
	// Helpers
	// ---------------------------------------------
	task step(input integer n);
	begin
		repeat (n) @(posedge clk);
		#1;
	end
	endtask
	task at(input tx, input f, input integer n);
	begin
		wait (cks[tx] == f);
		wait (cks[tx] != f);
		step(n);
	end
	endtask
	task check(input seen, input exp);
	begin
		checks = checks + 1;
		if (seen !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("ERROR %0t: got %b want %b", $time, seen, exp);
		end
	end
	endtask
	task wrap_up;
	begin
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	// ---------------------------------------------
	// Scenarios
	// ---------------------------------------------
	task t_pull;
	begin
		pin_used = 0;
		for (i = 0; i < 4; i = i + 1)
		begin
			cfg_active = !i[1];
			diff_capable = !i[1] & i[0];
			pulldown_sel = i[1] & i[0];
			step(3);
			check(pad_pullup, !(i[0]));
			check(pad_pulldown, pulldown_sel);
			check(pad_oe, 0);
		end
		{cfg_active, diff_capable, pulldown_sel, pin_used} = 4'h1;
		$display("pull test done");
	end
	endtask
	task t_rx;
	begin
		ext_val = 1;
		step(8);
		check(rx_rise_bit, 1);
		rx_reg_en = 1;
		for (i = 0; i < 2; i = i + 1)
		begin
			rx_edge_fall = i[0];
			ext_val = 1;
			step(12);
			at(0, i, 2);
			ext_val = 0;
			step(12);
			check(rx_rise_bit, 1);
			check(alternate_rx_path, 0);
			step(10);
			check(rx_rise_bit, 0);
		end
		rx_ddr = 1;
		for (i = 0; i < 8; i = i + 1)
		begin
			rx_resync = i[2];
			at(0, 1, 2);
			ext_val = i[0];
			at(0, 0, 2);
			ext_val = i[1];
			at(0, 1, 6);
			check(rx_rise_bit, i[0]);
			if (!i[2])
				check(rx_fall_bit, i[1]);
			else
			begin
				at(0, 0, 6);
				check(rx_fall_bit, i[1]);
			end
		end
		{rx_ddr, rx_reg_en} = 2'h0;
		$display("receive test done");
	end
	endtask
	task t_tx;
	begin
		mode = `MODE_OUTPUT;
		hi = 1;
		step(2);
		check(pad_o, 1);
		check(pad_oe, 1);
		tx_reg_en = 1;
		for (i = 0; i < 4; i = i + 1)
		begin
			{tx_invert, tx_edge_fall} = i[1:0];
			hi = 0;
			at(1, i[0], 5);
			hi = 1;
			step(9);
			check(pad_o, i[1]);
			step(10);
			check(pad_o, !i[1]);
		end
		{tx_invert, tx_ddr, lo} = 3'h2;
		for (i = 0; i < 2; i = i + 1)
		begin
			tx_resync = i;
			at(1, 0, 7);
			check(pad_o, 1);
			at(1, 1, 7);
			check(pad_o, 0);
		end
		{tx_ddr, tx_resync} = 2'h0;
		mode = `MODE_CLKOUT;
		at(0, 0, 6);
		check(pad_o, 1);
		at(0, 1, 6);
		check(pad_o, 0);
		$display("transmit test done");
	end
	endtask
	task t_bidir;
	begin
		mode = `MODE_BIDIR;
		{oe_reg_en, oe_in, ext_en, hi} = 4'hd;
		at(1, 0, 6);
		check(pad_oe, 1);
		check(pad_o, 1);
		step(6);
		check(rx_rise_bit, 1);
		oe_in = 0;
		at(1, 0, 6);
		check(pad_oe, 0);
		$display("bidirectional test done");
	end
	endtask
	initial
	begin
		step(12);
		rst = 0;
		step(2);
		t_pull;
		t_rx;
		t_tx;
		t_bidir;
		wrap_up;
	end
	// Watchdog: about eight times the expected run of 630 clk
	initial
	begin
		#200000;
		error_cnt = error_cnt + 1;
		wrap_up;
	end
endmodule
